// [include/pwc_map.svh]
// Register offsets, field positions, reset values and timing counts of the power wake control block
`ifndef PWC_MAP_SVH
`define PWC_MAP_SVH

`define PWC_CTL_OFFSET        12'h014
`define PWC_PHYRST_OFFSET     12'h018
`define PWC_BIT_SKIP_ANA      15
`define PWC_BIT_XTAL_INH      14
`define PWC_BIT_LPI_WAKE_EN   13
`define PWC_BIT_LPI_WAKE_STS  12
`define PWC_BIT_MAC_DOMAIN_SOFT_RESET      11
`define PWC_BIT_RES_CLR_STS   9
`define PWC_BIT_RES_CLR_EN    8
`define PWC_BIT_PHY_RESET_REQUEST_REQ   0
`define PWC_RST_SKIP_ANA      1'b0
`define PWC_RST_XTAL_INH      1'b0
`define PWC_RST_LPI_WAKE_EN   1'b0
`define PWC_RST_LPI_WAKE_STS  1'b0
`define PWC_RST_MAC_DOMAIN_SOFT_RESET      1'b0
`define PWC_RST_RES_CLR_STS   1'b0
`define PWC_RST_RES_CLR_EN    1'b1
`define PWC_RST_SUSP_MODE     2'h2
`define PWC_CLK_HZ            20000000
`define PWC_PHY_MIN_MS        4
`define PWC_PHY_EXT_MS        128
`define PWC_ANA_SETTLE_MS     100
`define PWC_MS_CYCLES(ms)     ((ms) * (`PWC_CLK_HZ / 1000))

`endif

// [include/pwc_pkg.sv]
// Types of the power wake control block
package pwc_pkg;
    typedef enum logic [1:0] {
        PWC_SUSP_ZERO,
        PWC_SUSP_ONE,
        PWC_SUSP_DEEP,
        PWC_SUSP_THREE
    } pwc_susp_t;

    typedef enum logic [1:0] {
        PWC_PHY_IDLE,
        PWC_PHY_HOLD,
        PWC_PHY_SETTLE
    } pwc_phy_state_t;

    typedef struct packed {
        logic           skipAnaWait;
        logic           xtalInhibit;
        logic           lpiWakeEn;
        logic           lpiWakeSts;
        logic           macSoftRst;
        logic           resClrSts;
        logic           resClrEn;
        pwc_phy_state_t phyState;
        logic [21:0]    phyCnt;
        logic           phyRstOut;
        logic           anaRefOn;
        logic           phyReady;
        logic           xtalStopOk;
        logic           lpiWakeEvt;
        logic           clrWakeSts;
        logic           clrWakeEn;
        logic           macRxRstN;
        logic           macTxRstN;
        logic [31:0]    rdata;
    } pwc_state_t;
endpackage

// [rtl/power_wake_control.sv]
// Power wake control: analog reference wait, crystal inhibit, low power idle wake, MAC soft reset, resume clears
`timescale 1ns/1ps
// What this block does
// R01 - Skip-wait bit set keeps analog reference on during PHY reset.
// R02 - With reference turned off, wait about 100 ms before PHY counts as ready.
// R03 - Crystal inhibit set never allows the oscillator to stop, even deep suspend.
// R04 - Low power idle wake status is a wake event only when enabled.
// R05 - Resume-clears-enables set: remote-wake resume completion clears low power idle wake enable.
// R06 - Low power idle wake status sets on its cause regardless of enable.
// R07 - Resume-clears-status set: remote-wake resume completion clears low power idle wake status.
// R08 - Software must not clear that status while changing suspend mode.
// R09 - MAC soft reset bit high holds MAC receive and transmit domains in reset.
// R10 - Software clears MAC soft reset itself; the bit never self-clears.
// R11 - MAC domain resets release only while their clocks run.
// R12 - Resume-clears-status clears listed frame and wake statuses in both registers.
// R13 - Resume-clears-status also clears wake cause bit one with the idle status.
// R14 - Only remote-wake resumes clear statuses; host resumes leave them unchanged.
// R15 - Resume-clears-status clear: no wake status changes after resume.
// R16 - Resume-clears-enables set: remote-wake resume clears every wake enable bit.
// R17 - Skip-wait and crystal inhibit bits survive protected resets.
// R18 - Bits 31:16 and 10 read zero; idle wake status clears on write one.
// R19 - Suspend selection encodes states zero to three; resets to deep state.
// R20 - Host resumes never clear wake enables.
// R21 - Software PHY reset holds at least 4 ms, up to 128 ms.
`include "pwc_map.svh"

module power_wake_control
    import pwc_pkg::*;
#(
    parameter int PHY_MIN_CYC   = `PWC_MS_CYCLES(`PWC_PHY_MIN_MS),
    parameter int PHY_EXT_CYC   = `PWC_MS_CYCLES(`PWC_PHY_EXT_MS),
    parameter int ANA_SETTLE_CYC = `PWC_MS_CYCLES(`PWC_ANA_SETTLE_MS)
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        protRst,
    input  wire logic [11:0] regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [31:0] regRdata,
    input  wire logic        lpiWakeCause,
    input  wire logic        resumeDone,
    input  wire logic        resumeRemote,
    input  wire logic [1:0]  suspendMode,
    input  wire logic        macRxClkRunning,
    input  wire logic        macTxClkRunning,
    output logic             phyReset,
    output logic             analogRefEnable,
    output logic             phyOperational,
    output logic             crystalStopAllowed,
    output logic             lowPowerIdleWakeEvent,
    output logic             clearWakeStatus,
    output logic             clearWakeEnables,
    output logic             macRxResetN,
    output logic             macTxResetN
);

    pwc_state_t stQ;
    pwc_state_t stD;

    logic       ctlWr;
    logic       phyWr;
    logic       remoteDone;
    logic [21:0] holdLen;

    // ===========================================================
    // Next state
    always_comb begin
        stD        = stQ;
        ctlWr      = regWrite && (regAddr == `PWC_CTL_OFFSET);
        phyWr      = regWrite && (regAddr == `PWC_PHYRST_OFFSET);
        remoteDone = resumeDone && resumeRemote; // R14 R20
        // Reference kept on means only the short hold is needed
        holdLen    = stQ.skipAnaWait ? 22'(PHY_MIN_CYC) : 22'(PHY_EXT_CYC); // R21

        if (ctlWr) begin
            stD.skipAnaWait = regWdata[`PWC_BIT_SKIP_ANA];
            stD.xtalInhibit = regWdata[`PWC_BIT_XTAL_INH];
            stD.lpiWakeEn   = regWdata[`PWC_BIT_LPI_WAKE_EN];
            stD.macSoftRst  = regWdata[`PWC_BIT_MAC_DOMAIN_SOFT_RESET]; // R10
            stD.resClrSts   = regWdata[`PWC_BIT_RES_CLR_STS];
            stD.resClrEn    = regWdata[`PWC_BIT_RES_CLR_EN];
            if (regWdata[`PWC_BIT_LPI_WAKE_STS]) begin
                stD.lpiWakeSts = 1'b0; // R18
            end
        end

        if (remoteDone && stQ.resClrEn) begin
            stD.lpiWakeEn = 1'b0; // R05 R16
        end
        if (remoteDone && stQ.resClrSts) begin
            stD.lpiWakeSts = 1'b0; // R07 R13
        end
        // Cause wins over any clear in the same cycle
        if (lpiWakeCause) begin
            stD.lpiWakeSts = 1'b1; // R06
        end

        stD.clrWakeSts = remoteDone && stQ.resClrSts; // R12 R13 R15
        stD.clrWakeEn  = remoteDone && stQ.resClrEn;  // R16
        stD.lpiWakeEvt = stQ.lpiWakeSts && stQ.lpiWakeEn; // R04
        stD.xtalStopOk = !stQ.xtalInhibit && (suspendMode == PWC_SUSP_DEEP); // R03 R19

        // PHY reset sequencing; writes ignored while reset is held
        unique case (stQ.phyState)
            PWC_PHY_IDLE: begin
                stD.phyRstOut = 1'b0;
                stD.anaRefOn  = 1'b1;
                if (phyWr && regWdata[`PWC_BIT_PHY_RESET_REQUEST_REQ]) begin
                    stD.phyState  = PWC_PHY_HOLD;
                    stD.phyCnt    = 22'h000000;
                    stD.phyRstOut = 1'b1;
                    stD.phyReady  = 1'b0;
                    stD.anaRefOn  = stQ.skipAnaWait; // R01
                end
            end
            PWC_PHY_HOLD: begin
                stD.phyCnt = stQ.phyCnt + 22'h000001;
                if (stQ.phyCnt >= holdLen - 22'h000001) begin
                    stD.phyRstOut = 1'b0;
                    stD.anaRefOn  = 1'b1;
                    stD.phyCnt    = 22'h000000;
                    if (stQ.anaRefOn) begin
                        stD.phyState = PWC_PHY_IDLE;
                        stD.phyReady = 1'b1;
                    end else begin
                        stD.phyState = PWC_PHY_SETTLE;
                    end
                end
            end
            PWC_PHY_SETTLE: begin
                stD.phyCnt = stQ.phyCnt + 22'h000001;
                if (stQ.phyCnt >= 22'(ANA_SETTLE_CYC) - 22'h000001) begin
                    stD.phyState = PWC_PHY_IDLE; // R02
                    stD.phyReady = 1'b1;
                end
            end
            default: begin
                stD.phyState = PWC_PHY_IDLE;
            end
        endcase

        stD.macRxRstN = !stQ.macSoftRst && macRxClkRunning; // R09 R11
        stD.macTxRstN = !stQ.macSoftRst && macTxClkRunning; // R09 R11

        stD.rdata = 32'h00000000; // R18
        if (regRead && (regAddr == `PWC_CTL_OFFSET)) begin
            stD.rdata[`PWC_BIT_SKIP_ANA]     = stQ.skipAnaWait;
            stD.rdata[`PWC_BIT_XTAL_INH]     = stQ.xtalInhibit;
            stD.rdata[`PWC_BIT_LPI_WAKE_EN]  = stQ.lpiWakeEn;
            stD.rdata[`PWC_BIT_LPI_WAKE_STS] = stQ.lpiWakeSts;
            stD.rdata[`PWC_BIT_MAC_DOMAIN_SOFT_RESET]     = stQ.macSoftRst;
            stD.rdata[`PWC_BIT_RES_CLR_STS]  = stQ.resClrSts;
            stD.rdata[`PWC_BIT_RES_CLR_EN]   = stQ.resClrEn;
        end else if (regRead && (regAddr == `PWC_PHYRST_OFFSET)) begin
            stD.rdata[`PWC_BIT_PHY_RESET_REQUEST_REQ] = (stQ.phyState != PWC_PHY_IDLE);
            stD.rdata[1]                    = stQ.phyReady;
        end
    end

    // ===========================================================
    // State register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stQ <= '{skipAnaWait: `PWC_RST_SKIP_ANA, xtalInhibit: `PWC_RST_XTAL_INH,
                     lpiWakeEn: `PWC_RST_LPI_WAKE_EN, lpiWakeSts: `PWC_RST_LPI_WAKE_STS,
                     macSoftRst: `PWC_RST_MAC_DOMAIN_SOFT_RESET, resClrSts: `PWC_RST_RES_CLR_STS,
                     resClrEn: `PWC_RST_RES_CLR_EN, phyState: PWC_PHY_IDLE,
                     phyCnt: 22'h000000, phyRstOut: 1'b0, anaRefOn: 1'b1, phyReady: 1'b1,
                     xtalStopOk: 1'b0, lpiWakeEvt: 1'b0, clrWakeSts: 1'b0, clrWakeEn: 1'b0,
                     macRxRstN: 1'b0, macTxRstN: 1'b0, rdata: 32'h00000000};
        end else if (protRst) begin
            // Protected bits keep their value across this reset
            stQ             <= '{skipAnaWait: stQ.skipAnaWait, xtalInhibit: stQ.xtalInhibit, // R17
                                 lpiWakeEn: `PWC_RST_LPI_WAKE_EN, lpiWakeSts: `PWC_RST_LPI_WAKE_STS,
                                 macSoftRst: `PWC_RST_MAC_DOMAIN_SOFT_RESET, resClrSts: `PWC_RST_RES_CLR_STS,
                                 resClrEn: `PWC_RST_RES_CLR_EN, phyState: PWC_PHY_IDLE,
                                 phyCnt: 22'h000000, phyRstOut: 1'b0, anaRefOn: 1'b1, phyReady: 1'b1,
                                 xtalStopOk: 1'b0, lpiWakeEvt: 1'b0, clrWakeSts: 1'b0, clrWakeEn: 1'b0,
                                 macRxRstN: 1'b0, macTxRstN: 1'b0, rdata: 32'h00000000};
        end else begin
            stQ <= stD;
        end
    end

    assign regRdata              = stQ.rdata;
    assign phyReset              = stQ.phyRstOut;
    assign analogRefEnable       = stQ.anaRefOn;
    assign phyOperational        = stQ.phyReady;
    assign crystalStopAllowed    = stQ.xtalStopOk;
    assign lowPowerIdleWakeEvent = stQ.lpiWakeEvt;
    assign clearWakeStatus       = stQ.clrWakeSts;
    assign clearWakeEnables      = stQ.clrWakeEn;
    assign macRxResetN           = stQ.macRxRstN;
    assign macTxResetN           = stQ.macTxRstN;

endmodule

// [tb/pwc_assertions.sv]
// Concurrent checks on the power wake control ports
`timescale 1ns/1ps
module pwc_checker (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    input wire logic        resumeDone,
    input wire logic        resumeRemote,
    input wire logic        macRxClkRunning,
    input wire logic        macTxClkRunning,
    input wire logic        phyReset,
    input wire logic        analogRefEnable,
    input wire logic        phyOperational,
    input wire logic        clearWakeStatus,
    input wire logic        clearWakeEnables,
    input wire logic        macRxResetN,
    input wire logic        macTxResetN
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========
    // Assertions
    mac_domain_soft_reset_hold_a: assert property (regWrite && regAddr == 12'h014 && regWdata[11] |-> ##2 !macRxResetN && !macTxResetN)
        else $error("MAC domains left out of reset");
    rx_clk_gate_a: assert property (!macRxClkRunning |=> !macRxResetN)
        else $error("Receive reset released without clock");
    tx_clk_gate_a: assert property (!macTxClkRunning |=> !macTxResetN)
        else $error("Transmit reset released without clock");
    host_resume_a: assert property (resumeDone && !resumeRemote |=> !clearWakeStatus && !clearWakeEnables)
        else $error("Host resume cleared wake state");
    rsvd_read_a: assert property (regRead |=> regRdata[31:16] == 16'h0000 && !regRdata[10])
        else $error("Reserved bits read nonzero");
    phy_start_a: assert property (regWrite && regAddr == 12'h018 && regWdata[0] && !phyReset && phyOperational
        |=> phyReset && !phyOperational)
        else $error("PHY reset did not start");
    phy_hold_a: assert property ($rose(phyReset) |-> phyReset [*8])
        else $error("PHY reset shorter than minimum");
    ana_ref_a: assert property (!phyReset |-> analogRefEnable)
        else $error("Analog reference off outside PHY reset");
    settle_wait_a: assert property ($rose(analogRefEnable) && !phyOperational |-> !phyOperational [*8])
        else $error("PHY ready before reference settled");
    cover property (resumeDone && resumeRemote ##1 clearWakeEnables);
    cover property ($fell(phyOperational));
    cover property ($fell(macRxResetN));
endmodule

// [tb/testbench.sv]
// Self-checking bench of the power wake control block
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module testbench;
    localparam int MIN = 8, EXT = 16, SET = 10;
    logic        core_clk = 0, rst = 1, protRst = 0, regWrite = 0, regRead = 0;
    logic        lpiWakeCause = 0, resumeDone = 0, resumeRemote = 0;
    logic        macRxClkRunning = 1, macTxClkRunning = 1;
    logic [1:0]  suspendMode = 2'h2;
    logic [11:0] regAddr = 12'h000;
    logic [31:0] regWdata = 32'h0, regRdata, v;
    logic        phyReset, analogRefEnable, phyOperational, crystalStopAllowed;
    logic        lowPowerIdleWakeEvent, clearWakeStatus, clearWakeEnables, macRxResetN, macTxResetN;
    int          fail_count = 0, tests_run = 0, n;
    // Small counts keep the PHY sequence short
    power_wake_control #(.PHY_MIN_CYC(MIN), .PHY_EXT_CYC(EXT), .ANA_SETTLE_CYC(SET)) u_dut (.*);
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // ==========
    // Bus and pulse helpers
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 v = regRdata;
    endtask
    task automatic cause();
        @(posedge core_clk);
        lpiWakeCause <= 1'b1;
        @(posedge core_clk);
        lpiWakeCause <= 1'b0;
        tick(2);
    endtask
    task automatic resume(input logic remote);
        @(posedge core_clk);
        resumeDone <= 1'b1;
        resumeRemote <= remote;
        @(posedge core_clk);
        resumeDone <= 1'b0;
        #1 v = {30'h0, clearWakeStatus, clearWakeEnables};
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========
    // Scenarios
    task automatic t_regs();
        rd(12'h014); `CHK("ctl reset", 32'h00000100, v)
        rd(12'h020); `CHK("unmapped", 32'h00000000, v)
        wr(12'h014, 32'hFFFFFFFF);
        rd(12'h014); `CHK("ctl ones", 32'h0000EB00, v)
        `CHK("rx held", 1'b0, macRxResetN)
        `CHK("tx held", 1'b0, macTxResetN)
        wr(12'h014, 32'h00000300);
        tick(2); `CHK("rx released", 1'b1, macRxResetN)
        macRxClkRunning <= 1'b0;
        tick(2); `CHK("rx no clock", 1'b0, macRxResetN)
        `CHK("tx clock on", 1'b1, macTxResetN)
        macRxClkRunning <= 1'b1;
        tick(1); `CHK("xtal deep", 1'b1, crystalStopAllowed)
        suspendMode <= 2'h1;
        tick(2); `CHK("xtal shallow", 1'b0, crystalStopAllowed)
        suspendMode <= 2'h2;
        wr(12'h014, 32'h00004300);
        tick(2); `CHK("xtal inhibit", 1'b0, crystalStopAllowed)
    endtask
    task automatic t_wake();
        wr(12'h014, 32'h00002300);
        cause(); `CHK("event on", 1'b1, lowPowerIdleWakeEvent)
        resume(1'b0); `CHK("host pulses", 32'h0, v)
        rd(12'h014); `CHK("after host", 32'h00003300, v)
        resume(1'b1); `CHK("remote pulses", 32'h3, v)
        rd(12'h014); `CHK("after remote", 32'h00000300, v)
        cause(); `CHK("event masked", 1'b0, lowPowerIdleWakeEvent)
        rd(12'h014); `CHK("status anyway", 32'h00001300, v)
        wr(12'h014, 32'h00001300);
        rd(12'h014); `CHK("write one clear", 32'h00000300, v)
        wr(12'h014, 32'h00002000);
        cause();
        resume(1'b1); `CHK("no clear pulses", 32'h0, v)
        rd(12'h014); `CHK("kept status", 32'h00003000, v)
    endtask
    task automatic t_phy(input logic skip);
        wr(12'h014, skip ? 32'h00008100 : 32'h00000100);
        wr(12'h018, 32'h00000001);
        #1 `CHK("phy held", 1'b1, phyReset)
        `CHK("ref during reset", skip, analogRefEnable)
        for (n = 0; n < 100 && phyOperational !== 1'b1; n++) tick(1);
        if (n == 100) begin
            fail_count++;
            results();
        end
        if (skip) `CHK("fast ready", 1'b1, n == MIN)
        else `CHK("slow ready", 1'b1, n == EXT + SET)
        `CHK("phy released", 1'b0, phyReset)
        `CHK("ref restored", 1'b1, analogRefEnable)
        rd(12'h018); `CHK("phy idle read", 32'h00000002, v)
    endtask
    task automatic t_prot();
        wr(12'h014, 32'h0000C300);
        protRst <= 1'b1;
        tick(1);
        protRst <= 1'b0;
        rd(12'h014); `CHK("protected kept", 32'h0000C100, v)
        rst <= 1'b1;
        tick(1);
        rst <= 1'b0;
        rd(12'h014); `CHK("full reset", 32'h00000100, v)
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_wake();
        t_phy(1'b0);
        t_phy(1'b1);
        t_prot();
        results();
    end
endmodule
bind power_wake_control pwc_checker u_chk (.*);
